/* design/ksm_pkg.sv */
// package for the key slot manager: slot layout, policies, states, events
// assumes a synchronous single-clock system with one-cycle nvm handshakes
package ksm_pkg;

  // ----------------------------------------
  // slot geometry
  // ----------------------------------------
  localparam int          NUM_SLOTS     = 250;
  localparam int          SLOT_W        = 8;
  localparam int          VALUE_W       = 128;
  localparam int          WORD_W        = 32;
  localparam int          VALUE_WORDS   = 4;

  // ----------------------------------------
  // source structure byte offsets
  // ----------------------------------------
  localparam logic [31:0] VALUE_OFS      = 32'h0000_0000;
  localparam logic [31:0] POLICY_OFS     = 32'h0000_0010;
  localparam logic [31:0] TARGET_OFS     = 32'h0000_0014;
  localparam logic [31:0] TAG_OFS        = 32'h0000_0018;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;

  // ----------------------------------------
  // revocation policy codes
  // ----------------------------------------
  localparam logic [1:0]  POL_RESERVED  = 2'h0;
  localparam logic [1:0]  POL_ROTATING  = 2'h1;
  localparam logic [1:0]  POL_LOCKED    = 2'h2;
  localparam logic [1:0]  POL_PERMANENT = 2'h3;

  // ----------------------------------------
  // slot life states held in nvm
  // ----------------------------------------
  localparam logic [1:0]  SLOT_ERASED      = 2'h0;
  localparam logic [1:0]  SLOT_PROVISIONED = 2'h1;
  localparam logic [1:0]  SLOT_REVOKED     = 2'h2;

  // ----------------------------------------
  // event flag bit positions
  // ----------------------------------------
  localparam int          EV_STORED    = 0;
  localparam int          EV_DELIVERED = 1;
  localparam int          EV_REVOKED   = 2;
  localparam int          EV_ERROR     = 3;
  localparam int          EV_TAG       = 4;
  localparam int          EV_LOCKED    = 5;
  localparam int          EV_W         = 6;
  localparam logic [5:0]  EV_RESET     = 6'h00;

  typedef enum logic [2:0] {
    KSM_OP_STORE   = 3'h0,
    KSM_OP_DELIVER = 3'h1,
    KSM_OP_REVOKE  = 3'h2,
    KSM_OP_TAG     = 3'h3,
    KSM_OP_DLOCK   = 3'h4,
    KSM_OP_BLOCK   = 3'h5
  } ksm_op_type;

  // one slot as held in the protected key region
  typedef struct packed {
    logic [1:0]   state;
    logic [1:0]   revocation_policy;
    logic [31:0]  delivery_destination;
    logic [31:0]  tag;
    logic [127:0] value;
  } ksm_slot_type;

  // system bus master request (reads from ram, writes to destination)
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ksm_bus_req_type;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } ksm_bus_rsp_type;

endpackage

/* design/ksm_slot_store.sv */
// protected key region: slot array with per-slot volatile lock bits
// assumes writes commit only when the caller asserts commit with power good
`timescale 1ns/1ps
module ksm_slot_store
(
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  // access
  input  wire logic [7:0]            i_slot,
  input  wire logic                  i_commit,
  input  wire ksm_pkg::ksm_slot_type i_wdata,
  input  wire logic                  i_erase_all,
  input  wire logic                  i_set_dlock,
  input  wire logic                  i_set_block,
  output      ksm_pkg::ksm_slot_type o_rdata,
  output      logic                  o_dlocked,
  output      logic                  o_blocked
);
  import ksm_pkg::*;

  // array models nonvolatile cells, so reset does not touch it
  ksm_slot_type         mem_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] dlock_q;
  logic [NUM_SLOTS-1:0] block_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_erase_all)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
        mem_q[i] <= '0;
    end
    else if (i_commit)
      mem_q[i_slot] <= i_wdata;
  end

  // locks are volatile: gone at the next reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      dlock_q <= '0;
      block_q <= '0;
    end
    else
    begin
      if (i_set_dlock)
        dlock_q[i_slot] <= 1'b1;
      if (i_set_block)
        block_q[i_slot] <= 1'b1;
    end
  end

  always_comb
  begin
    o_rdata   = mem_q[i_slot];
    o_dlocked = dlock_q[i_slot];
    o_blocked = block_q[i_slot];
  end

endmodule

/* design/ksm_bus_port.sv */
// single-word bus master port with registered request
// assumes the system bus answers each request with a one-cycle done pulse
`timescale 1ns/1ps
module ksm_bus_port
(
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst,
  // from the sequencer
  input  wire logic                     i_start,
  input  wire logic                     i_we,
  input  wire logic [31:0]              i_addr,
  input  wire logic [31:0]              i_wdata,
  output      logic                     o_busy,
  // system bus
  output      ksm_pkg::ksm_bus_req_type o_bus,
  input  wire ksm_pkg::ksm_bus_rsp_type i_bus
);
  import ksm_pkg::*;

  ksm_bus_req_type st_q;
  ksm_bus_req_type st_d;

  always_comb
  begin
    st_d = st_q;
    if (i_start && !st_q.req)
      st_d = '{req: 1'b1, we: i_we, addr: i_addr, wdata: i_wdata};
    else if (i_bus.done)
      st_d.req = 1'b0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_bus  = st_q;
  assign o_busy = st_q.req;

endmodule

/* design/ksm_key_manager.sv */
// key_manager top: slot operations sequencer with event flags
// assumes a secure-mode qualifier, power-good level and an erase-all strobe from the system
//
// How it works
// - a slot holds 128-bit value, 32-bit tag, 32-bit destination, 2-bit policy
// - one operation at a time; triggers while busy are dropped
// - store succeeds only on an erased slot, otherwise slot untouched
// - store copies the source structure from ram; stored or error event
// - source: value byte 0, policy byte 16, destination byte 20, tag byte 24
// - policy low two bits: 11 permanent, 01 rotating, 10 locked, 00 reserved
// - revoking rotating slot erases it; permanent slot stays revoked
// - revoke on locked-policy slot leaves it unchanged and raises error
// - power failure during store commits nothing
// - deliver writes value to destination only if provisioned and not locked
// - deliver raises delivered, revoked if slot revoked, else error
// - delivered depends only on all four bus writes completing without a bus error
// - tag fetch on provisioned slot copies tag to register, raises event
// - tag fetch ends at once: revoked slot gives revoked, erased gives error
// - revoke erases secret and raises revoked; error if failed or already revoked
// - revoked non-rotating slots stay unusable until erase-all
// - delivery lock on provisioned slot blocks delivery until reset, raises event
// - full block stops deliver, store and revoke of the slot until reset
// - accesses only in secure mode; only this block reaches the region
// - the secret value is never returned on any read path
// - store, deliver or revoke on a blocked slot raises error, no change
// - slot select addresses 250 slots of 128 bits each
`timescale 1ns/1ps
module ksm_key_manager
(
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst,
  // task triggers, one-cycle pulses
  input  wire logic                     i_task_store,
  input  wire logic                     i_task_deliver,
  input  wire logic                     i_task_revoke,
  input  wire logic                     i_task_tag_fetch_operation,
  input  wire logic                     i_task_delivery_lock_operation,
  input  wire logic                     i_task_block,
  // configuration
  input  wire logic [7:0]               i_slot_select,
  input  wire logic [31:0]              i_source_pointer,
  input  wire logic                     i_secure,
  input  wire logic                     i_power_good,
  input  wire logic                     i_erase_all,
  input  wire logic [5:0]               i_event_clear,
  // status
  output      logic [5:0]               o_events,
  output      logic [31:0]              o_tag,
  output      logic                     o_busy,
  // system bus master
  output      ksm_pkg::ksm_bus_req_type o_bus,
  input  wire ksm_pkg::ksm_bus_rsp_type i_bus
);
  import ksm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    KSM_IDLE  = 3'b000,
    KSM_CHECK = 3'b001,
    KSM_XFER  = 3'b011,
    KSM_WAIT  = 3'b010,
    KSM_DONE  = 3'b110
  } ksm_fsm_type;

  typedef struct packed {
    ksm_fsm_type  fsm;
    ksm_op_type   op;
    logic [7:0]   slot;
    logic [2:0]   idx;
    logic         fail;
    logic [5:0]   outcome;
    ksm_slot_type buf_slot;
    logic [5:0]   events;
    logic [31:0]  tag;
    logic         busy;
  } ksm_state_type;

  ksm_state_type st_q;
  ksm_state_type st_d;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] ev_bit(input int pos);
    logic [5:0] v;
    v      = '0;
    v[pos] = 1'b1;
    return v;
  endfunction

  // source structure word address for transfer index
  function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [2:0] idx);
    logic [31:0] ofs;
    ofs = WORD_BYTES * {29'h0, idx};
    return base + VALUE_OFS + ofs;
  endfunction

  // ----------------------------------------
  // slot store and bus port
  // ----------------------------------------
  ksm_slot_type rd_slot;
  logic         rd_dlocked;
  logic         rd_blocked;
  logic         commit;
  ksm_slot_type wr_slot;
  logic         set_dlock;
  logic         set_block;
  logic         bus_start;
  logic         bus_we;
  logic [31:0]  bus_addr;
  logic [31:0]  bus_wdata;
  logic         bus_busy;

  ksm_slot_store u_store
  (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_slot      (st_q.slot),
    .i_commit    (commit),
    .i_wdata     (wr_slot),
    .i_erase_all (i_erase_all),
    .i_set_dlock (set_dlock),
    .i_set_block (set_block),
    .o_rdata     (rd_slot),
    .o_dlocked   (rd_dlocked),
    .o_blocked   (rd_blocked)
  );

  ksm_bus_port u_bus
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (bus_start),
    .i_we      (bus_we),
    .i_addr    (bus_addr),
    .i_wdata   (bus_wdata),
    .o_busy    (bus_busy),
    .o_bus     (o_bus),
    .i_bus     (i_bus)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic       any_task;
  ksm_op_type new_op;
  logic       slot_ok;

  always_comb
  begin
    any_task = i_task_store | i_task_deliver | i_task_revoke | i_task_tag_fetch_operation |
               i_task_delivery_lock_operation | i_task_block;
    new_op   = KSM_OP_STORE;
    if (i_task_deliver)
      new_op = KSM_OP_DELIVER;
    else if (i_task_revoke)
      new_op = KSM_OP_REVOKE;
    else if (i_task_tag_fetch_operation)
      new_op = KSM_OP_TAG;
    else if (i_task_delivery_lock_operation)
      new_op = KSM_OP_DLOCK;
    else if (i_task_block)
      new_op = KSM_OP_BLOCK;
    slot_ok = (i_slot_select < 8'(NUM_SLOTS));
  end

  always_comb
  begin
    st_d      = st_q;
    commit    = 1'b0;
    wr_slot   = rd_slot;
    set_dlock = 1'b0;
    set_block = 1'b0;
    bus_start = 1'b0;
    bus_we    = 1'b0;
    bus_addr  = '0;
    bus_wdata = '0;
    case (st_q.fsm)
      KSM_IDLE:
      begin
        // non-secure triggers are refused outright
        if (any_task && i_secure && slot_ok)
        begin
          st_d.op   = new_op;
          st_d.slot = i_slot_select;
          st_d.idx  = '0;
          st_d.fail = 1'b0;
          st_d.busy = 1'b1;
          st_d.fsm  = KSM_CHECK;
        end
      end
      KSM_CHECK:
      begin
        st_d.fsm     = KSM_DONE;
        st_d.outcome = ev_bit(EV_ERROR);
        st_d.buf_slot = rd_slot;
        case (st_q.op)
          KSM_OP_STORE:
            if (!rd_blocked && rd_slot.state == SLOT_ERASED)
              st_d.fsm = KSM_XFER;
          KSM_OP_DELIVER:
            if (rd_blocked)
              st_d.outcome = ev_bit(EV_ERROR);
            else if (rd_slot.state == SLOT_REVOKED)
              st_d.outcome = ev_bit(EV_REVOKED);
            else if (rd_slot.state == SLOT_PROVISIONED && !rd_dlocked)
              st_d.fsm = KSM_XFER;
          KSM_OP_REVOKE:
            if (!rd_blocked && rd_slot.state == SLOT_PROVISIONED &&
                rd_slot.revocation_policy != POL_LOCKED)
            begin
              // secret wiped in both cases; rotating returns to erased
              wr_slot = '0;
              if (rd_slot.revocation_policy != POL_ROTATING)
              begin
                wr_slot.state             = SLOT_REVOKED;
                wr_slot.revocation_policy = rd_slot.revocation_policy;
              end
              commit       = 1'b1;
              st_d.outcome = ev_bit(EV_REVOKED);
            end
          KSM_OP_TAG:
            if (rd_slot.state == SLOT_REVOKED)
              st_d.outcome = ev_bit(EV_REVOKED);
            else if (rd_slot.state == SLOT_PROVISIONED)
            begin
              st_d.tag     = rd_slot.tag;
              st_d.outcome = ev_bit(EV_TAG);
            end
          KSM_OP_DLOCK:
            if (rd_slot.state == SLOT_PROVISIONED)
            begin
              set_dlock    = 1'b1;
              st_d.outcome = ev_bit(EV_LOCKED);
            end
          KSM_OP_BLOCK:
          begin
            // no event is defined for success; a plain completion
            set_block    = 1'b1;
            st_d.outcome = '0;
          end
          default:
            st_d.outcome = ev_bit(EV_ERROR);
        endcase
      end
      KSM_XFER:
      begin
        bus_start = 1'b1;
        if (st_q.op == KSM_OP_STORE)
        begin
          bus_we   = 1'b0;
          bus_addr = word_addr(i_source_pointer, st_q.idx);
        end
        else
        begin
          // one word per beat to consecutive destination words
          bus_we    = 1'b1;
          bus_addr  = st_q.buf_slot.delivery_destination + WORD_BYTES * {29'h0, st_q.idx};
          bus_wdata = st_q.buf_slot.value[st_q.idx[1:0]*WORD_W +: WORD_W];
        end
        st_d.fsm = KSM_WAIT;
      end
      KSM_WAIT:
      begin
        if (i_bus.done)
        begin
          st_d.fail = st_q.fail | i_bus.err;
          if (st_q.op == KSM_OP_STORE)
          begin
            case (st_q.idx)
              POLICY_OFS[4:2]: st_d.buf_slot.revocation_policy = i_bus.rdata[1:0];
              TARGET_OFS[4:2]: st_d.buf_slot.delivery_destination = i_bus.rdata;
              TAG_OFS[4:2]:    st_d.buf_slot.tag = i_bus.rdata;
              default: st_d.buf_slot.value[st_q.idx[1:0]*WORD_W +: WORD_W] = i_bus.rdata;
            endcase
          end
          st_d.idx = st_q.idx + 3'h1;
          if ((st_q.op == KSM_OP_STORE && st_q.idx == TAG_OFS[4:2]) ||
              (st_q.op != KSM_OP_STORE && st_q.idx == 3'h3))
          begin
            st_d.fsm = KSM_DONE;
            if (st_q.op == KSM_OP_STORE)
            begin
              wr_slot       = st_d.buf_slot;
              wr_slot.state = SLOT_PROVISIONED;
              // reserved policy and bus faults abort; power loss skips commit
              if (st_d.fail || st_d.buf_slot.revocation_policy == POL_RESERVED || !i_power_good)
                st_d.outcome = ev_bit(EV_ERROR);
              else
              begin
                commit       = 1'b1;
                st_d.outcome = ev_bit(EV_STORED);
              end
            end
            else
              st_d.outcome = st_d.fail ? ev_bit(EV_ERROR) : ev_bit(EV_DELIVERED);
          end
          else
            st_d.fsm = KSM_XFER;
        end
      end
      KSM_DONE:
      begin
        st_d.buf_slot = '0;
        st_d.busy     = 1'b0;
        st_d.fsm      = KSM_IDLE;
      end
      default:
        st_d.fsm = KSM_IDLE;
    endcase
    // set wins over a clear in the same cycle
    st_d.events = (st_q.events & ~i_event_clear) |
                  ((st_q.fsm == KSM_DONE) ? st_q.outcome : EV_RESET);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      st_q <= '{fsm: KSM_IDLE, op: KSM_OP_STORE, events: EV_RESET, default: '0};
    else
      st_q <= st_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_events = st_q.events;
  assign o_tag    = st_q.tag;
  assign o_busy   = st_q.busy;

  logic unused_bus_busy;
  assign unused_bus_busy = bus_busy;

endmodule

/* test/ksm_key_manager_properties.sv */
// checker: timing relations at the key manager ports
// assumes a bind to ksm_key_manager, one clock, synchronous reset
`timescale 1ns/1ps
module ksm_key_manager_checker
(
  input wire logic                     i_ref_clk,
  input wire logic                     i_rst,
  input wire logic                     i_task_store,
  input wire logic                     i_task_deliver,
  input wire logic                     i_task_revoke,
  input wire logic                     i_task_tag_fetch_operation,
  input wire logic                     i_task_delivery_lock_operation,
  input wire logic                     i_task_block,
  input wire logic [7:0]               i_slot_select,
  input wire logic [31:0]              i_source_pointer,
  input wire logic                     i_secure,
  input wire logic [5:0]               i_event_clear,
  input wire logic [5:0]               o_events,
  input wire logic                     o_busy,
  input wire ksm_pkg::ksm_bus_req_type o_bus,
  input wire ksm_pkg::ksm_bus_rsp_type i_bus
);
  import ksm_pkg::*;
  // ------------------------------
  // helpers
  // ------------------------------
  logic [5:0] keep_q;
  wire logic  any_trig = i_task_store | i_task_deliver | i_task_revoke | i_task_tag_fetch_operation
                         | i_task_delivery_lock_operation | i_task_block;
  wire logic  can_take = !o_busy && i_secure && (i_slot_select < NUM_SLOTS) && any_trig;
  // flags that must survive; cleared in reset so a short reset cannot leave stale bits
  always_ff @(posedge i_ref_clk)
    keep_q <= i_rst ? 6'h00 : (o_events & ~i_event_clear);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // ------------------------------
  // assertions
  // ------------------------------
  a_reset_idle: assert property (disable iff (1'b0) i_rst |=> o_events == 6'h00 && !o_busy && !o_bus.req)
    else $error("outputs not idle after reset");
  a_event_sticky: assert property ((o_events & keep_q) == keep_q)
    else $error("event flag dropped without clear");
  a_req_in_op: assert property (o_bus.req |-> o_busy)
    else $error("bus request outside an operation");
  a_insecure_drop: assert property (!o_busy && !i_secure |=> !o_busy)
    else $error("trigger taken outside secure mode");
  a_slot_range: assert property (!o_busy && i_slot_select >= NUM_SLOTS |=> !o_busy)
    else $error("trigger taken on slot out of range");
  a_trigger_taken: assert property (can_take |=> o_busy)
    else $error("legal trigger not taken");
  a_op_bounded: assert property ($rose(o_busy) |-> ##[1:600] !o_busy)
    else $error("operation never ends");
  a_end_event: assert property ($fell(o_busy) && !$past(i_rst) && !$past(i_task_block, 3) |-> o_events != 6'h00)
    else $error("operation ended with no event");
  a_req_held: assert property (o_bus.req && !i_bus.done |=>
    o_bus.req && $stable(o_bus.addr) && $stable(o_bus.we))
    else $error("bus request changed before done");
  a_read_window: assert property (o_bus.req && !o_bus.we |->
    o_bus.addr - i_source_pointer <= 32'h18 && o_bus.addr[1:0] == 2'h0)
    else $error("read outside source structure");
endmodule

bind ksm_key_manager ksm_key_manager_checker u_chk
(
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_task_store(i_task_store), .i_task_deliver(i_task_deliver),
  .i_task_revoke(i_task_revoke), .i_task_tag_fetch_operation(i_task_tag_fetch_operation),
  .i_task_delivery_lock_operation(i_task_delivery_lock_operation), .i_task_block(i_task_block),
  .i_slot_select(i_slot_select), .i_source_pointer(i_source_pointer), .i_secure(i_secure),
  .i_event_clear(i_event_clear), .o_events(o_events), .o_busy(o_busy), .o_bus(o_bus), .i_bus(i_bus)
);

/* test/ksm_bus_model.sv */
// system bus partner: word array standing for ram and key destinations
// assumes one request at a time held until the done pulse
`timescale 1ns/1ps
module ksm_bus_model
(
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst,
  // behaviour control
  input  wire logic [3:0]               i_delay,
  input  wire logic                     i_err,
  // system bus
  input  wire ksm_pkg::ksm_bus_req_type i_bus,
  output      ksm_pkg::ksm_bus_rsp_type o_rsp
);
  import ksm_pkg::*;
  logic [31:0] mem [0:255];
  logic [3:0]  cnt_q;
  logic        done_q;
  logic [31:0] rd_q;
  // read data is inverted outside done so a stale word never passes
  assign o_rsp = '{done: done_q, err: done_q & i_err, rdata: done_q ? rd_q : ~rd_q};
  always @(posedge i_ref_clk)
  begin
    if (i_rst || done_q || !i_bus.req)
    begin
      done_q <= 1'b0;
      cnt_q  <= 4'h0;
    end
    else if (cnt_q == i_delay)
    begin
      done_q <= 1'b1;
      rd_q   <= mem[i_bus.addr[9:2]];
      if (i_bus.we && !i_err)
        mem[i_bus.addr[9:2]] <= i_bus.wdata;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

/* test/ksm_key_manager_test.sv */
// testbench: task triggers with expected outcome events of the key manager
// assumes the bus model holds the source structure at byte 0x100
`timescale 1ns/1ps
module ksm_key_manager_test;
  import ksm_pkg::*;
  // ------------------------------
  // signals
  // ------------------------------
  localparam logic [5:0] ST = 6'h01 << EV_STORED;
  localparam logic [5:0] DL = 6'h01 << EV_DELIVERED;
  localparam logic [5:0] RV = 6'h01 << EV_REVOKED;
  localparam logic [5:0] ER = 6'h01 << EV_ERROR;
  localparam logic [5:0] TG = 6'h01 << EV_TAG;
  localparam logic [5:0] LK = 6'h01 << EV_LOCKED;
  logic            clk;
  logic            rst;
  logic            secure;
  logic            pgood;
  logic            erase;
  logic            berr;
  logic [3:0]      dly;
  logic [5:0]      trig;
  logic [5:0]      evclr;
  logic [5:0]      ev;
  logic [7:0]      slot;
  logic [31:0]     tag;
  logic            busy;
  ksm_bus_req_type bus;
  ksm_bus_rsp_type rsp;
  int              fails;
  int              samples_checked;
  ksm_key_manager dut
  (
    .i_ref_clk                      (clk),
    .i_rst                          (rst),
    .i_task_store                   (trig[KSM_OP_STORE]),
    .i_task_deliver                 (trig[KSM_OP_DELIVER]),
    .i_task_revoke                  (trig[KSM_OP_REVOKE]),
    .i_task_tag_fetch_operation     (trig[KSM_OP_TAG]),
    .i_task_delivery_lock_operation (trig[KSM_OP_DLOCK]),
    .i_task_block                   (trig[KSM_OP_BLOCK]),
    .i_slot_select                  (slot),
    .i_source_pointer               (32'h0000_0100),
    .i_secure                       (secure),
    .i_power_good                   (pgood),
    .i_erase_all                    (erase),
    .i_event_clear                  (evclr),
    .o_events                       (ev),
    .o_tag                          (tag),
    .o_busy                         (busy),
    .o_bus                          (bus),
    .i_bus                          (rsp)
  );
  ksm_bus_model u_bus
  (
    .i_ref_clk (clk),
    .i_rst     (rst),
    .i_delay   (dly),
    .i_err     (berr),
    .i_bus     (bus),
    .o_rsp     (rsp)
  );
  // ------------------------------
  // tasks
  // ------------------------------
  function automatic logic [31:0] val(input logic [7:0] s, input int i);
    return {s, 8'(i), 16'ha5c3};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic fill_ram(input logic [31:0] pol, input logic [7:0] s);
    for (int i = 0; i < 4; i++)
      u_bus.mem[64 + i] = val(s, i);
    u_bus.mem[68] = pol;
    u_bus.mem[69] = 32'h0000_0200 + {20'h0, s, 4'h0};
    u_bus.mem[70] = {24'h13579b, s};
  endtask
  // k2 fires a second trigger while the first operation is running
  task automatic op(input ksm_op_type k, input int k2, input logic [7:0] s, input logic [5:0] exp, input string nm);
    int n;
    tick(1);
    evclr = 6'h3f;
    tick(1);
    evclr = 6'h00;
    slot = s;
    trig[k] = 1'b1;
    tick(1);
    trig = 6'h00;
    if (k2 >= 0)
    begin
      tick(1);
      trig[k2] = 1'b1;
      tick(1);
      trig = 6'h00;
    end
    n = 0;
    while (ev === 6'h00 && n < 300)
    begin
      tick(1);
      n++;
    end
    tick(2);
    chk({nm, " events"}, {26'h0, ev}, {26'h0, exp});
    chk({nm, " busy"}, {31'h0, busy}, 32'h0);
    $display("test %s done", nm);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------
  // clock, watchdog, sequence
  // ------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // about twenty times the expected run length
  initial
  begin
    #3_000_000;
    fails++;
    stop_test();
  end
  initial
  begin
    rst = 1'b1;
    secure = 1'b1;
    pgood = 1'b1;
    erase = 1'b0;
    berr = 1'b0;
    dly = 4'h0;
    trig = 6'h00;
    evclr = 6'h00;
    slot = 8'h00;
    tick(16);
    rst = 1'b0;
    erase = 1'b1;
    tick(1);
    erase = 1'b0;
    fill_ram(32'(POL_ROTATING), 8'h05);
    op(KSM_OP_STORE, KSM_OP_DELIVER, 8'h05, ST, "store busy");
    op(KSM_OP_TAG, -1, 8'h05, TG, "tag");
    chk("tag value", tag, 32'h13579b05);
    op(KSM_OP_DELIVER, -1, 8'h05, DL, "deliver");
    for (int i = 0; i < 4; i++)
      chk("key word", u_bus.mem[148 + i], val(8'h05, i));
    op(KSM_OP_STORE, -1, 8'h05, ER, "store full");
    op(KSM_OP_REVOKE, -1, 8'h05, RV, "revoke rot");
    op(KSM_OP_TAG, -1, 8'h05, ER, "tag erased");
    op(KSM_OP_DELIVER, -1, 8'h05, ER, "deliver erased");
    fill_ram(32'(POL_LOCKED), 8'h06);
    op(KSM_OP_STORE, -1, 8'h06, ST, "store lock");
    op(KSM_OP_REVOKE, -1, 8'h06, ER, "revoke lock");
    berr = 1'b1;
    op(KSM_OP_DELIVER, -1, 8'h06, ER, "deliver buserr");
    berr = 1'b0;
    dly = 4'h3;
    fill_ram(32'(POL_PERMANENT), 8'h07);
    op(KSM_OP_STORE, -1, 8'h07, ST, "store slow");
    op(KSM_OP_REVOKE, -1, 8'h07, RV, "revoke perm");
    op(KSM_OP_REVOKE, -1, 8'h07, ER, "revoke again");
    op(KSM_OP_TAG, -1, 8'h07, RV, "tag revoked");
    op(KSM_OP_DELIVER, -1, 8'h07, RV, "deliver revoked");
    op(KSM_OP_STORE, -1, 8'h07, ER, "store revoked");
    dly = 4'h0;
    fill_ram(32'(POL_ROTATING), 8'h08);
    op(KSM_OP_STORE, -1, 8'h08, ST, "store dlock");
    op(KSM_OP_DLOCK, -1, 8'h08, LK, "dlock");
    op(KSM_OP_DELIVER, -1, 8'h08, ER, "deliver dlocked");
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    op(KSM_OP_DELIVER, -1, 8'h08, DL, "deliver after reset");
    fill_ram(32'(POL_ROTATING), 8'h09);
    op(KSM_OP_STORE, -1, 8'h09, ST, "store block");
    op(KSM_OP_BLOCK, -1, 8'h09, 6'h00, "block");
    op(KSM_OP_STORE, -1, 8'h09, ER, "store blocked");
    op(KSM_OP_DELIVER, -1, 8'h09, ER, "deliver blocked");
    op(KSM_OP_REVOKE, -1, 8'h09, ER, "revoke blocked");
    op(KSM_OP_TAG, -1, 8'h09, TG, "tag blocked");
    fill_ram(32'(POL_ROTATING), 8'h0a);
    pgood = 1'b0;
    op(KSM_OP_STORE, -1, 8'h0a, ER, "store power fail");
    pgood = 1'b1;
    op(KSM_OP_TAG, -1, 8'h0a, ER, "tag after fail");
    fill_ram(32'(POL_RESERVED), 8'h0b);
    op(KSM_OP_STORE, -1, 8'h0b, ER, "store reserved");
    op(KSM_OP_TAG, -1, 8'hfa, 6'h00, "slot range");
    secure = 1'b0;
    op(KSM_OP_TAG, -1, 8'h08, 6'h00, "insecure");
    secure = 1'b1;
    erase = 1'b1;
    tick(1);
    erase = 1'b0;
    fill_ram(32'(POL_ROTATING), 8'h07);
    op(KSM_OP_STORE, -1, 8'h07, ST, "store after erase");
    stop_test();
  end
endmodule
